// File: core/umd_uart_core.sv
// Functional notes
// - Parity mode field set to multidrop selects wake-up multidrop operation.
// - Frame is start, data bits, one tag bit, programmed stop bits.
// - Tag one marks an address character, tag zero a data character.
// - Tag polarity select field chooses the transmitted tag value.
// - In multidrop the receiver watches the line even while disabled.
// - Disabled receiver stores tag-one characters and raises the ready flag.
// - Disabled receiver drops tag-zero characters untouched.
// - Enabled receiver in multidrop delivers every character through the FIFO.
// - Data goes to the data slot, tag to the parity error slot.
// - Framing, overrun and break detection work as in normal operation.
// - Multidrop neither generates nor checks parity.
// - Reads return bytes; reserved locations read as zero.
// - Writes to read-only or reserved locations end normally and are dropped.
// - Register accesses finish with zero wait states.
// - Word or byte accesses allowed; only the low byte carries data.
// - Interrupt acknowledge returns the vector number register.
// - Ready flag shows a waiting character; reading the buffer pops it.
module umd_uart_core
    import umd_pkg::*;
#(
    parameter logic [15:0] BIT_CLKS = BIT_CLKS_DEF
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        cpuSel,
    input  wire logic        cpuWr,
    input  wire logic [5:0]  cpuAddr,
    input  wire logic [15:0] cpuWdata,
    input  wire logic        iackStrobe,
    input  wire logic        rxPin,
    output logic [15:0]      cpuRdata,
    output logic             cpuAck,
    output logic             txPin,
    output logic             rxReadyFlag,
    output logic             fifoFullFlag,
    output logic             txReady
);
    typedef struct packed {
        logic        rxMeta;
        logic        rxSync;
        logic [7:0]  modeRegOne;
        logic [7:0]  modeRegTwo;
        logic [7:0]  vectorNumberReg;
        logic        modePtr;
        logic        rxEnable;
        logic        txEnable;
        logic [7:0]  txHold;
        logic        txHoldFull;
        logic [11:0] txShift;
        logic [3:0]  txLeft;
        logic [15:0] txDiv;
        logic        txPin;
        logic        overrun;
        logic [7:0]  rdByte;
        logic        cpuAck;
        logic        rxReadyFlag;
        logic        fifoFullFlag;
        logic        txReady;
    } umd_core_t;

    umd_core_t   s;
    umd_core_t   n;
    logic        rdStb;
    logic        wrStb;
    logic [1:0]  parityModeField;
    logic        tagPolaritySel;
    logic        multiDrop;
    logic        extraOn;
    logic [3:0]  dataBits;
    logic        extraVal;
    logic [11:0] frm;
    logic [3:0]  frmLen;
    logic [7:0]  statByte;
    logic [2:0]  fifoCount;
    logic        flush;
    logic        accept;
    logic        overSet;
    logic        rxDone;
    logic [7:0]  rxData;
    logic        rxExtra;
    logic        rxFrame;
    logic        rxBreak;
    logic [2:0]  cmdMisc;

    umd_stream_if #(.W(ENT_W)) pushS ();
    umd_stream_if #(.W(ENT_W)) popS ();

    // Mode decode
    assign parityModeField = s.modeRegOne[MR1_PM_LSB +: 2];
    assign tagPolaritySel  = s.modeRegOne[MR1_PT];
    assign multiDrop       = (parityModeField == PM_MULTI);
    assign extraOn         = (parityModeField != PM_NONE);
    assign dataBits        = LEN_BASE + {2'h0, s.modeRegOne[MR1_LEN_LSB +: 2]};
    assign rdStb           = cpuSel && !cpuWr;
    assign wrStb           = cpuSel && cpuWr;
    assign cmdMisc         = cpuWdata[CMD_MISC_LSB +: 3];

    // Transmitted tag follows polarity select; parity only outside multidrop
    assign extraVal = multiDrop ? tagPolaritySel
                                : (^(s.txHold & (8'hff >> (4'h8 - dataBits)))) ^ tagPolaritySel;

    // Receive character handling
    umd_rx_frame u_rx (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .rxLine    (s.rxSync),
        .bitClks   (BIT_CLKS),
        .dataBits  (dataBits),
        .extraOn   (extraOn),
        .charDone  (rxDone),
        .charData  (rxData),
        .charExtra (rxExtra),
        .charFrame (rxFrame),
        .charBreak (rxBreak)
    );

    // Disabled receiver keeps only address-tagged characters in multidrop
    assign accept = s.rxEnable || (multiDrop && rxExtra);
    assign pushS.valid = rxDone && accept;
    assign pushS.data  = {rxBreak, rxFrame,
                          multiDrop ? rxExtra
                                    : (parityModeField == PM_PARITY) &&
                                      ((^rxData) ^ tagPolaritySel ^ rxExtra) != 1'b0,
                          rxData};
    assign overSet     = pushS.valid && !pushS.ready;
    assign popS.ready  = rdStb && (cpuAddr == ADDR_BUF);

    umd_fifo #(.W(ENT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .flush   (flush),
        .inS     (pushS),
        .outS    (popS),
        .count   (fifoCount)
    );

    // Status byte shows the character at the top of the FIFO
    assign statByte[ST_RX_READY_FLAG] = s.rxReadyFlag;
    assign statByte[ST_FIFO_FULL_FLAG] = s.fifoFullFlag;
    assign statByte[ST_TXRDY] = !s.txHoldFull;
    assign statByte[ST_TXEMP] = !s.txHoldFull && (s.txLeft == '0);
    assign statByte[ST_OVR]   = s.overrun;
    assign statByte[ST_TAG]   = popS.valid && popS.data[ENT_TAG];
    assign statByte[ST_FRAME] = popS.valid && popS.data[ENT_FRAME];
    assign statByte[ST_BREAK] = popS.valid && popS.data[ENT_BREAK];

    // Outputs straight from the state register
    assign cpuRdata     = {8'h00, s.rdByte};
    assign cpuAck       = s.cpuAck;
    assign txPin        = s.txPin;
    assign rxReadyFlag  = s.rxReadyFlag;
    assign fifoFullFlag = s.fifoFullFlag;
    assign txReady      = s.txReady;

    // Next state: CPU port, transmitter, commands
    always_comb begin
        n        = s;
        flush    = 1'b0;
        n.rxMeta = rxPin;
        n.rxSync = s.rxMeta;
        n.cpuAck = cpuSel || iackStrobe;
        n.rdByte = 8'h00;
        // Frame image, least significant bit first
        frm    = '1;
        frm[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < dataBits) frm[i+1] = s.txHold[i];
        end
        if (extraOn) frm[dataBits + 4'h1] = extraVal;
        frmLen = 4'h2 + dataBits + {3'h0, extraOn} + {3'h0, s.modeRegTwo[MR2_STOP2]};
        // Register reads
        if (iackStrobe) n.rdByte = s.vectorNumberReg;
        else if (rdStb) begin
            case (cpuAddr)
                ADDR_MODE: n.rdByte = s.modePtr ? s.modeRegTwo : s.modeRegOne;
                ADDR_STAT: n.rdByte = statByte;
                ADDR_BUF:  n.rdByte = popS.valid ? popS.data[7:0] : 8'h00;
                ADDR_VEC:  n.rdByte = s.vectorNumberReg;
                default:   n.rdByte = 8'h00;
            endcase
        end
        // Register writes, low byte only
        if (wrStb) begin
            case (cpuAddr)
                ADDR_MODE: begin
                    if (!s.modePtr) n.modeRegOne = cpuWdata[7:0];
                    else n.modeRegTwo = cpuWdata[7:0];
                    n.modePtr = 1'b1;
                end
                ADDR_BUF: if (!s.txHoldFull) begin
                    n.txHold     = cpuWdata[7:0];
                    n.txHoldFull = 1'b1;
                end
                ADDR_VEC: n.vectorNumberReg = cpuWdata[7:0];
                default: ;
            endcase
        end
        // Transmitter bit timing; mode is sampled at frame load
        if (s.txLeft != '0) begin
            if (s.txDiv != '0) n.txDiv = s.txDiv - 16'h1;
            else begin
                n.txDiv   = BIT_CLKS - 16'h1;
                n.txLeft  = s.txLeft - 4'h1;
                n.txShift = {1'b1, s.txShift[11:1]};
                n.txPin   = (s.txLeft == 4'h1) ? 1'b1 : s.txShift[1];
            end
        end else if (s.txHoldFull && s.txEnable) begin
            n.txShift    = frm;
            n.txPin      = 1'b0;
            n.txLeft     = frmLen;
            n.txDiv      = BIT_CLKS - 16'h1;
            n.txHoldFull = 1'b0;
        end
        // Commands
        if (wrStb && cpuAddr == ADDR_CMD) begin
            if (cpuWdata[CMD_RX_LSB +: 2] == EN_ON) n.rxEnable = 1'b1;
            if (cpuWdata[CMD_RX_LSB +: 2] == EN_OFF) n.rxEnable = 1'b0;
            if (cpuWdata[CMD_TX_LSB +: 2] == EN_ON) n.txEnable = 1'b1;
            if (cpuWdata[CMD_TX_LSB +: 2] == EN_OFF) n.txEnable = 1'b0;
            case (cmdMisc)
                MISC_MRPTR: n.modePtr = 1'b0;
                MISC_RXRST: begin
                    n.rxEnable = 1'b0;
                    n.overrun  = 1'b0;
                    flush      = 1'b1;
                end
                MISC_TXRST: begin
                    n.txEnable   = 1'b0;
                    n.txHoldFull = 1'b0;
                    n.txLeft     = '0;
                    n.txPin      = 1'b1;
                end
                MISC_ERRRST: n.overrun = 1'b0;
                default: ;
            endcase
        end
        // A new overrun wins over a clear in the same cycle
        if (overSet) n.overrun = 1'b1;
        n.rxReadyFlag  = (fifoCount != 3'h0);
        n.fifoFullFlag = (fifoCount == 3'(FIFO_DEPTH));
        n.txReady      = !n.txHoldFull;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s                 <= '0;
            s.rxMeta          <= 1'b1;
            s.rxSync          <= 1'b1;
            s.modeRegOne      <= MODE_RST;
            s.modeRegTwo      <= MODE_RST;
            s.vectorNumberReg <= VEC_RST;
            s.txPin           <= 1'b1;
        end else begin
            s <= n;
        end
    end

    ack_timing_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (cpuSel || iackStrobe) |=> cpuAck) else $error("access not answered next cycle");

    byte_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
        cpuSel |=> cpuRdata[15:8] == 8'h00) else $error("upper data byte not zero");

    reserved_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (rdStb && !iackStrobe && cpuAddr != ADDR_MODE && cpuAddr != ADDR_STAT &&
         cpuAddr != ADDR_BUF && cpuAddr != ADDR_VEC) |=> cpuRdata == 16'h0000)
        else $error("reserved read not zero");

    vector_drive_a: assert property (@(posedge mclk) disable iff (sys_rst)
        iackStrobe |=> cpuRdata[7:0] == $past(s.vectorNumberReg)) else $error("wrong vector");

    tag_drop_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (rxDone && !s.rxEnable && multiDrop && !rxExtra) |-> !pushS.valid)
        else $error("data character kept while disabled");

    tag_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (rxDone && multiDrop && rxExtra && pushS.ready) |-> ##2 s.rxReadyFlag)
        else $error("address character not flagged");

    tag_slot_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (pushS.valid && multiDrop) |-> pushS.data[ENT_TAG] == rxExtra)
        else $error("tag not in parity slot");

    tx_start_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (s.txLeft == 4'h0 && s.txHoldFull && s.txEnable) |=> !txPin ##1 !txPin)
        else $error("start bit missing");

    tx_tag_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (s.txLeft == 4'h0 && s.txHoldFull && s.txEnable && multiDrop)
        |=> s.txShift[dataBits + 4'h1] == $past(tagPolaritySel))
        else $error("tag polarity wrong");

    overrun_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        overSet |=> s.overrun) else $error("overrun not flagged");
endmodule : umd_uart_core

// File: include/umd_pkg.sv
package umd_pkg;
    // Register byte addresses on the CPU port
    localparam logic [5:0] ADDR_MODE = 6'h00;
    localparam logic [5:0] ADDR_STAT = 6'h04;
    localparam logic [5:0] ADDR_CMD  = 6'h08;
    localparam logic [5:0] ADDR_BUF  = 6'h0c;
    localparam logic [5:0] ADDR_VEC  = 6'h30;

    // Mode register one fields
    localparam int         MR1_LEN_LSB = 0;
    localparam int         MR1_PT      = 2;
    localparam int         MR1_PM_LSB  = 3;
    localparam logic [1:0] PM_PARITY   = 2'h0;
    localparam logic [1:0] PM_NONE     = 2'h2;
    localparam logic [1:0] PM_MULTI    = 2'h3;
    localparam logic [3:0] LEN_BASE    = 4'h5;

    // Mode register two fields
    localparam int         MR2_STOP2   = 0;

    // Command register fields and codes
    localparam int         CMD_RX_LSB  = 0;
    localparam int         CMD_TX_LSB  = 2;
    localparam int         CMD_MISC_LSB = 4;
    localparam logic [1:0] EN_ON       = 2'h1;
    localparam logic [1:0] EN_OFF      = 2'h2;
    localparam logic [2:0] MISC_MRPTR  = 3'h1;
    localparam logic [2:0] MISC_RXRST  = 3'h2;
    localparam logic [2:0] MISC_TXRST  = 3'h3;
    localparam logic [2:0] MISC_ERRRST = 3'h4;

    // Status register bit positions
    localparam int ST_RX_READY_FLAG = 0;
    localparam int ST_FIFO_FULL_FLAG = 1;
    localparam int ST_TXRDY = 2;
    localparam int ST_TXEMP = 3;
    localparam int ST_OVR   = 4;
    localparam int ST_TAG   = 5;
    localparam int ST_FRAME = 6;
    localparam int ST_BREAK = 7;

    // Receive FIFO entry layout
    localparam int ENT_W      = 11;
    localparam int ENT_TAG    = 8;
    localparam int ENT_FRAME  = 9;
    localparam int ENT_BREAK  = 10;
    localparam int FIFO_DEPTH = 4;

    // Reset values and bit timing
    localparam logic [7:0]  MODE_RST     = 8'h00;
    localparam logic [7:0]  VEC_RST      = 8'h0f;
    localparam logic [15:0] BIT_CLKS_DEF = 16'h0010;
endpackage : umd_pkg

// File: include/umd_stream_if.sv
interface umd_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : umd_stream_if

// File: core/umd_fifo.sv
module umd_fifo
    import umd_pkg::*;
#(
    parameter int W     = ENT_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic                       mclk,
    input  wire logic                       sys_rst,
    input  wire logic                       flush,
    umd_stream_if.snk                       inS,
    umd_stream_if.src                       outS,
    output logic [$clog2(DEPTH+1)-1:0]      count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           rd;
        logic [AW-1:0]           wr;
        logic [CW-1:0]           cnt;
    } umd_fifo_t;

    umd_fifo_t s;
    umd_fifo_t n;
    logic      push;
    logic      pop;

    // Honest flags straight from the occupancy count
    assign inS.ready  = (s.cnt != CW'(DEPTH));
    assign outS.valid = (s.cnt != '0);
    assign outS.data  = s.mem[s.rd];
    assign count      = s.cnt;
    assign push       = inS.valid && inS.ready;
    assign pop        = outS.valid && outS.ready;

    // Pointer and count update, flush empties the store
    always_comb begin
        n = s;
        if (push) begin
            n.mem[s.wr] = inS.data;
            n.wr        = s.wr + 1'b1;
        end
        if (pop) n.rd = s.rd + 1'b1;
        case ({push, pop})
            2'b10:   n.cnt = s.cnt + 1'b1;
            2'b01:   n.cnt = s.cnt - 1'b1;
            default: n.cnt = s.cnt;
        endcase
        if (flush) begin
            n.rd  = '0;
            n.wr  = '0;
            n.cnt = '0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) s <= '0;
        else s <= n;
    end

    fifo_bound_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.cnt <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule : umd_fifo

// File: core/umd_rx_frame.sv
module umd_rx_frame
    import umd_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        rxLine,
    input  wire logic [15:0] bitClks,
    input  wire logic [3:0]  dataBits,
    input  wire logic        extraOn,
    output logic             charDone,
    output logic [7:0]       charData,
    output logic             charExtra,
    output logic             charFrame,
    output logic             charBreak
);
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_HOLD} umd_rx_state_t;

    typedef struct packed {
        umd_rx_state_t state;
        logic [15:0]   div;
        logic [3:0]    idx;
        logic [8:0]    sh;
        logic          done;
        logic [7:0]    data;
        logic          extra;
        logic          frame;
        logic          brk;
    } umd_rx_t;

    umd_rx_t    s;
    umd_rx_t    n;
    logic [3:0] nb;

    assign nb        = dataBits + {3'h0, extraOn};
    assign charDone  = s.done;
    assign charData  = s.data;
    assign charExtra = s.extra;
    assign charFrame = s.frame;
    assign charBreak = s.brk;

    // Start detect, mid-bit sampling, stop check, break hold-off
    always_comb begin
        n      = s;
        n.done = 1'b0;
        unique case (s.state)
            RX_IDLE: if (!rxLine) begin
                n.state = RX_START;
                n.div   = bitClks >> 1;
                n.sh    = '0;
            end
            RX_START: begin
                if (s.div != '0) n.div = s.div - 16'h1;
                else if (!rxLine) begin
                    n.state = RX_BITS;
                    n.div   = bitClks - 16'h1;
                    n.idx   = '0;
                end else n.state = RX_IDLE;
            end
            RX_BITS: begin
                if (s.div != '0) n.div = s.div - 16'h1;
                else begin
                    n.sh[s.idx] = rxLine;
                    n.div       = bitClks - 16'h1;
                    n.idx       = s.idx + 4'h1;
                    if (s.idx + 4'h1 == nb) n.state = RX_STOP;
                end
            end
            RX_STOP: begin
                if (s.div != '0) n.div = s.div - 16'h1;
                else begin
                    n.done  = 1'b1;
                    n.data  = s.sh[7:0] & (8'hff >> (4'h8 - dataBits));
                    n.extra = extraOn & s.sh[dataBits];
                    n.frame = !rxLine;
                    n.brk   = !rxLine && (s.sh == '0);
                    n.state = rxLine ? RX_IDLE : RX_HOLD;
                end
            end
            RX_HOLD: if (rxLine) n.state = RX_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) s <= '0;
        else s <= n;
    end

    done_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.done |=> !s.done) else $error("character done held too long");
endmodule : umd_rx_frame

// File: test/umd_station.sv
module umd_station #(
    parameter int BIT = 4
) (
    input  wire logic mclk,
    output logic      line,
    input  wire logic txLine
);
    timeunit 1ns;
    timeprecision 100ps;

    // Line idles high between frames
    initial line = 1'b1;

    // Master frame: start, data lsb first, tag, one stop
    task automatic send(input logic [7:0] d, input logic tag);
        logic [10:0] fr;
        fr = {1'b1, tag, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line = fr[i];
            repeat (BIT) @(negedge mclk);
        end
    endtask : send

    // Slave side: samples each bit near its centre, away from the launching edge
    task automatic recv(output logic [7:0] d, output logic tag, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        while (txLine !== 1'b0 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        if (n < 200) begin
            repeat (BIT / 2) @(negedge mclk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(negedge mclk);
                d[i] = txLine;
            end
            repeat (BIT) @(negedge mclk);
            tag = txLine;
            repeat (BIT) @(negedge mclk);
            ok = (txLine === 1'b1);
        end
    endtask : recv
endmodule : umd_station

// File: test/tb.sv
module tb
    import umd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk, sys_rst, cpuSel, cpuWr, iackStrobe, rxPin, cpuAck, txPin;
    logic        rxReadyFlag, fifoFullFlag, txReady, rt, ok;
    logic [5:0]  cpuAddr;
    logic [15:0] cpuWdata, cpuRdata, r16;
    logic [7:0]  rb, sw;
    int          errors, samples_checked;
    localparam logic [7:0] IDLE = 8'(1 << ST_TXRDY) | 8'(1 << ST_TXEMP);
    localparam logic [7:0] RDY  = 8'(1 << ST_RX_READY_FLAG);
    localparam logic [7:0] TAG  = 8'(1 << ST_TAG);

    // Free running clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    umd_uart_core #(.BIT_CLKS(16'h0004)) dut (.mclk(mclk), .sys_rst(sys_rst), .cpuSel(cpuSel),
        .cpuWr(cpuWr), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .iackStrobe(iackStrobe),
        .rxPin(rxPin), .cpuRdata(cpuRdata), .cpuAck(cpuAck), .txPin(txPin),
        .rxReadyFlag(rxReadyFlag), .fifoFullFlag(fifoFullFlag), .txReady(txReady));
    umd_station #(.BIT(4)) u (.mclk(mclk), .line(rxPin), .txLine(txPin));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic results();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // One access; ack and data are due the cycle after the request
    task automatic acc(input logic w, input logic ia, input logic [5:0] a, input logic [7:0] d);
        @(negedge mclk);
        cpuSel = ~ia;
        iackStrobe = ia;
        cpuWr = w;
        cpuAddr = a;
        cpuWdata = {8'hff, d}; // Upper byte is junk on purpose
        @(negedge mclk);
        cpuSel = 1'b0;
        iackStrobe = 1'b0;
        chk(16'(cpuAck), 16'h0001);
        r16 = cpuRdata;
    endtask : acc

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        acc(1'b0, 1'b0, a, 8'h00);
        chk(r16, {8'h00, e});
    endtask : rd

    task automatic wait_rdy();
        int n;
        n = 0;
        while (rxReadyFlag !== 1'b1 && n < 60) begin
            @(negedge mclk);
            n++;
        end
        if (rxReadyFlag !== 1'b1) begin
            errors++;
            results();
        end else begin
            chk(16'(rxReadyFlag), 16'h0001);
        end
    endtask : wait_rdy

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        {cpuSel, cpuWr, iackStrobe} = 3'h0;
        cpuAddr = 6'h00;
        cpuWdata = 16'h0000;
        errors = 0;
        samples_checked = 0;
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
        rd(ADDR_STAT, IDLE);
        acc(1'b0, 1'b1, 6'h00, 8'h00);
        chk(r16, {8'h00, VEC_RST});
        wr(ADDR_CMD, {1'b0, MISC_RXRST, 4'h0});
        wr(ADDR_CMD, {1'b0, MISC_TXRST, 4'h0});
        wr(ADDR_CMD, {1'b0, MISC_MRPTR, 4'h0});
        wr(ADDR_VEC, 8'h5a);
        acc(1'b0, 1'b1, 6'h00, 8'h00);
        chk(r16, 16'h005a);
        wr(ADDR_MODE, {3'h0, PM_MULTI, 1'b1, 2'h3});
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_CMD, {1'b0, MISC_MRPTR, 4'h0});
        rd(ADDR_MODE, {3'h0, PM_MULTI, 1'b1, 2'h3});
        wr(6'h3c, 8'hff);
        rd(6'h3c, 8'h00);
        wr(ADDR_STAT, 8'hff);
        rd(ADDR_STAT, IDLE);
        u.send(8'ha5, 1'b1);
        wait_rdy();
        rd(ADDR_STAT, IDLE | RDY | TAG);
        rd(ADDR_BUF, 8'ha5);
        rd(ADDR_STAT, IDLE);
        u.send(8'h33, 1'b0);
        repeat (20) @(negedge mclk);
        chk(16'(rxReadyFlag), 16'h0000);
        wr(ADDR_CMD, {6'h00, EN_ON});
        u.send(8'h3c, 1'b0);
        wait_rdy();
        rd(ADDR_STAT, IDLE | RDY);
        rd(ADDR_BUF, 8'h3c);
        for (int i = 0; i < 5; i++) u.send(8'h10 + 8'(i), 1'b1);
        repeat (20) @(negedge mclk);
        chk(16'(fifoFullFlag), 16'h0001);
        rd(ADDR_STAT, IDLE | RDY | TAG | 8'(1 << ST_FIFO_FULL_FLAG) | 8'(1 << ST_OVR));
        for (int i = 0; i < 4; i++) rd(ADDR_BUF, 8'h10 + 8'(i));
        @(negedge mclk);
        chk(16'(rxReadyFlag), 16'h0000);
        wr(ADDR_CMD, {1'b0, MISC_ERRRST, 4'h0});
        rd(ADDR_STAT, IDLE);
        // Plain parity mode, even: good parity then bad parity in the status tag slot
        wr(ADDR_CMD, {1'b0, MISC_MRPTR, 4'h0});
        wr(ADDR_MODE, {3'h0, PM_PARITY, 1'b0, 2'h3});
        u.send(8'h01, 1'b1);
        wait_rdy();
        rd(ADDR_STAT, IDLE | RDY);
        rd(ADDR_BUF, 8'h01);
        u.send(8'h01, 1'b0);
        wait_rdy();
        rd(ADDR_STAT, IDLE | RDY | TAG);
        rd(ADDR_BUF, 8'h01);
        for (int p = 0; p < 2; p++) begin
            wr(ADDR_CMD, {1'b0, MISC_MRPTR, 4'h0});
            wr(ADDR_MODE, {3'h0, PM_MULTI, 1'(p), 2'h3});
            wr(ADDR_CMD, {4'h0, EN_ON, 2'h0});
            sw = {^(7'h43 ^ 7'(p)), 7'h43 ^ 7'(p)};
            wr(ADDR_BUF, sw);
            chk(16'(txReady), 16'h0000);
            u.recv(rb, rt, ok);
            if (ok !== 1'b1) begin
                errors++;
                results();
            end
            chk({8'h00, rb}, {8'h00, sw});
            chk(16'(^rb), 16'h0000);
            chk(16'(rt), 16'(p));
            chk(16'(txReady), 16'h0001);
        end
        results();
    end
endmodule : tb
